//--- hdl/pll_band_and_lock_regs.sv
// Band select, factory trim and lock status registers of a dual-loop synthesizer.
// Assumes a register port driven by the serial control front end; trims load from factory straps.
`timescale 1ns/1ns
module pll_band_and_lock_regs #(
  parameter logic [1:0] MASK_VARIANT = 2'h2 // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [31:0] i_trim_a,
  input wire logic [31:0] i_trim_b,
  input wire logic [30:0] i_trim_band1,
  input wire logic [30:0] i_trim_band2,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_first_loop_locked,
  input wire logic i_second_loop_locked,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_first_band,
  output logic o_second_band
);
  ////////////////////////////////////////////////////////////////
  // Storage, decode and read words
  logic [31:0] trim_a_q;
  logic [31:0] trim_b_q;
  logic [30:0] band1_trim_q;
  logic [30:0] band2_trim_q;
  logic lock1_s;
  logic lock2_s;
  logic hit_trim_a;
  logic hit_band1;
  logic hit_trim_b;
  logic hit_band2;
  logic hit_lock;
  logic wr_band1;
  logic wr_band2;
  logic first_band_d;
  logic second_band_d;
  logic [31:0] band1_word;
  logic [31:0] band2_word;
  logic [31:0] status_word;
  logic [31:0] rdata_d;

  ////////////////////////////////////////////////////////////////
  // Lock level synchronisers
  level_sync u_sync1 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_level(i_first_loop_locked),
    .o_level(lock1_s)
  );
  level_sync u_sync2 (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_level(i_second_loop_locked),
    .o_level(lock2_s)
  );

  ////////////////////////////////////////////////////////////////
  // Address decode
  always_comb begin
    hit_trim_a = (i_addr == band_regs_pkg::TRIM_A_ADDR);
    hit_band1 = (i_addr == band_regs_pkg::BAND1_ADDR);
    hit_trim_b = (i_addr == band_regs_pkg::TRIM_B_ADDR);
    hit_band2 = (i_addr == band_regs_pkg::BAND2_ADDR);
    hit_lock = (i_addr == band_regs_pkg::LOCK_ADDR);
  end

  // Only the two band words take writes
  assign wr_band1 = i_wr && hit_band1;
  assign wr_band2 = i_wr && hit_band2;

  ////////////////////////////////////////////////////////////////
  // Factory words: loaded by strobe, never written by the port
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      trim_a_q <= band_regs_pkg::ZERO_WORD;
    end else if (i_load) begin
      trim_a_q <= i_trim_a;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      trim_b_q <= band_regs_pkg::ZERO_WORD;
    end else if (i_load) begin
      trim_b_q <= i_trim_b;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      band1_trim_q <= band_regs_pkg::TRIM_RST;
    end else if (i_load) begin
      band1_trim_q <= i_trim_band1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      band2_trim_q <= band_regs_pkg::TRIM_RST;
    end else if (i_load) begin
      band2_trim_q <= i_trim_band2;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Band bits: only bit 31 is writable
  always_comb begin
    first_band_d = o_first_band;
    second_band_d = o_second_band;
    if (wr_band1) begin
      first_band_d = i_wdata[band_regs_pkg::BAND_BIT];
    end
    if (wr_band2) begin
      second_band_d = i_wdata[band_regs_pkg::BAND_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_first_band <= band_regs_pkg::BAND_RST;
    end else begin
      o_first_band <= first_band_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_second_band <= band_regs_pkg::BAND_RST;
    end else begin
      o_second_band <= second_band_d;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Whole words as software sees them
  assign band1_word = {o_first_band, band1_trim_q};
  assign band2_word = {o_second_band, band2_trim_q};

  // Status word: lock flags and variant code, all else zero
  always_comb begin
    status_word = band_regs_pkg::ZERO_WORD;
    status_word[band_regs_pkg::LOCK2_BIT] = lock2_s;
    status_word[band_regs_pkg::LOCK1_BIT] = lock1_s;
    status_word[band_regs_pkg::REV_LSB +: band_regs_pkg::REV_W] = MASK_VARIANT;
  end

  ////////////////////////////////////////////////////////////////
  // Read mux, unmapped addresses read zero
  always_comb begin
    rdata_d = band_regs_pkg::ZERO_WORD;
    if (hit_trim_a) begin
      rdata_d = trim_a_q;
    end
    if (hit_band1) begin
      rdata_d = band1_word;
    end
    if (hit_trim_b) begin
      rdata_d = trim_b_q;
    end
    if (hit_band2) begin
      rdata_d = band2_word;
    end
    if (hit_lock) begin
      rdata_d = status_word;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read response, one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rvalid <= 1'h0;
    end else begin
      o_rvalid <= i_rd;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= band_regs_pkg::ZERO_WORD;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end
  end
endmodule // pll_band_and_lock_regs

//--- hdl/band_regs_pkg.sv
// Package: register map, field positions and reset values of the band/lock register group.
// Assumes a simple register access port provided by the serial control front end.
package band_regs_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [4:0] TRIM_A_ADDR = 5'h0B;
  localparam logic [4:0] BAND1_ADDR = 5'h0C;
  localparam logic [4:0] TRIM_B_ADDR = 5'h0D;
  localparam logic [4:0] BAND2_ADDR = 5'h0E;
  localparam logic [4:0] LOCK_ADDR = 5'h0F;
  localparam int BAND_BIT = 31;
  localparam int LOCK2_BIT = 23;
  localparam int LOCK1_BIT = 21;
  localparam int REV_LSB = 17;
  localparam int REV_W = 2;
  localparam logic BAND_RST = 1'h0;
  localparam logic [30:0] TRIM_RST = 31'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

//--- hdl/level_sync.sv
// Two-flop synchroniser for a level from an analog block.
// Assumes the level changes slowly relative to the clock.
`timescale 1ns/1ns
module level_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_level,
  output logic o_level
);
  logic meta_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= 1'h0;
      o_level <= 1'h0;
    end else begin
      meta_q <= i_level;
      o_level <= meta_q;
    end
  end
endmodule // level_sync

//--- bench/bchk_properties.sv
// Checker for the band and lock registers.
// Bound into the register block.
`timescale 1ns/1ns
module bchk #(
  parameter logic [1:0] MASK_VARIANT = 2'h2
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic o_rvalid,
  input wire logic o_first_band,
  input wire logic o_second_band,
  input wire logic i_first_loop_locked,
  input wire logic i_second_loop_locked,
  input wire logic [4:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] o_rdata
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_read_pulse: assert property (i_rd |=> o_rvalid) else $error("rvalid");
  chk_pulse_ends: assert property (!i_rd |=> !o_rvalid) else $error("rvalid stays");
  chk_rdata_hold: assert property (!i_rd |=> $stable(o_rdata)) else $error("rdata moved");
  chk_lock_bits: assert property (i_rd && i_addr == 5'h0F && $past(i_rst_n) && $past(i_rst_n, 2)
    |=> {o_rdata[23], o_rdata[21]} == $past({i_second_loop_locked, i_first_loop_locked}, 3)) else $error("lock");
  chk_variant_code: assert property (i_rd && i_addr == 5'h0F |=> o_rdata[18:17] == MASK_VARIANT)
    else $error("rev");
  chk_first_write: assert property (i_wr && i_addr == 5'h0C |=> o_first_band == $past(i_wdata[31]))
    else $error("first band");
  chk_first_hold: assert property (!(i_wr && i_addr == 5'h0C) |=> $stable(o_first_band))
    else $error("first hold");
  chk_band_write: assert property (i_wr && i_addr == 5'h0E |=> o_second_band == $past(i_wdata[31]))
    else $error("band");
  chk_band_hold: assert property (!(i_wr && i_addr == 5'h0E) |=> $stable(o_second_band))
    else $error("hold");
  cover property (i_rd && i_addr == 5'h0F);
  cover property (i_wr && i_wdata[31]);
  cover property (i_wr && i_addr == 5'h0B);
  cover property (i_wr && i_addr == 5'h0E && !i_wdata[31]);
endmodule // bchk
bind pll_band_and_lock_regs bchk #(
  .MASK_VARIANT(MASK_VARIANT)
) u_bchk (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rvalid(o_rvalid),
  .o_first_band(o_first_band),
  .o_second_band(o_second_band),
  .i_first_loop_locked(i_first_loop_locked),
  .i_second_loop_locked(i_second_loop_locked),
  .i_addr(i_addr),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata)
);

//--- bench/hm.sv
// Host model for the register port.
// Drives on falling edges.
`timescale 1ns/1ns
module hm (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr = '0,
  output logic o_rd = '0,
  output logic [4:0] o_addr = '0,
  output logic [31:0] o_wdata = '0
);
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(negedge i_clk) {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_clk) {o_wr, o_wdata} = {1'b0, ~d};
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic ok);
    @(negedge i_clk) {o_rd, o_addr} = {1'h1, a};
    @(negedge i_clk) begin
      o_rd = 1'h0;
      d = i_rdata;
      ok = i_rvalid;
    end
  endtask
  task automatic band(input logic [4:0] a, f, output logic ok);
    logic [31:0] v;
    rd(a, v, ok);
    wr(a, {f > 5'h0D, v[30:0]});
  endtask
endmodule // hm

//--- bench/pll_band_and_lock_regs_test.sv
// Testbench for the band and lock registers.
// Host model drives the port.
`timescale 1ns/1ns
module pll_band_and_lock_regs_test;
  logic i_clk = 0, i_rst_n = 0, ld = 0, l1 = 0, l2 = 0, w, r, b1, b2, rvl, ok1, ok2;
  logic [4:0] a, fs [4] = '{5'h00, 5'h0D, 5'h0E, 5'h1B};
  logic [31:0] wd, rv, v;
  int n_mismatch = 0, comparisons = 0;
  initial forever #4 i_clk = ~i_clk;
  pll_band_and_lock_regs u_pll_band_and_lock_regs (.i_clk, .i_rst_n, .i_load(ld), .i_trim_a(32'hA),
    .i_trim_b(32'hB), .i_trim_band1(31'hC), .i_trim_band2(31'hD), .i_wr(w), .i_rd(r), .i_addr(a),
    .i_wdata(wd), .i_first_loop_locked(l1), .i_second_loop_locked(l2), .o_rdata(rv), .o_rvalid(rvl),
    .o_first_band(b1), .o_second_band(b2));
  hm u_hm (.i_clk, .i_rdata(rv), .i_rvalid(rvl), .o_wr(w), .o_rd(r), .o_addr(a), .o_wdata(wd));
  task automatic ck(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000 n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (16) @(negedge i_clk);
    {i_rst_n, ld} = 2'h3;
    @(negedge i_clk) ld = 0;
    u_hm.wr(5'h0B, 32'h0);
    u_hm.rd(5'h0B, v, ok1);
    ck("trim", v, 32'h0000_000A);
    ck("trim_rvalid", ok1, 1'h1);
    foreach (fs[k]) begin
      u_hm.band(5'h0C, fs[k], ok1);
      u_hm.band(5'h0E, 5'h1B - fs[k], ok2);
      ck("band", {b2, b1}, {5'h1B - fs[k] > 5'h0D, fs[k] > 5'h0D});
      ck("band_rvalid", {ok2, ok1}, 2'h3);
    end
    u_hm.rd(5'h0C, v, ok1);
    ck("band1_word", v, 32'h8000_000C);
    u_hm.wr(5'h0E, 32'h0);
    u_hm.rd(5'h0E, v, ok2);
    ck("band_word", v, 32'h0000_000D);
    for (int j = 0; j < 4; j++) begin
      {l2, l1} = j[1:0];
      u_hm.wr(5'h0F, 32'hFFFF_FFFF);
      u_hm.rd(5'h0F, v, ok1);
      ck("status", v, {8'h0, j[1], 1'h0, j[0], 4'h2, 17'h0});
      ck("status_rvalid", ok1, 1'h1);
    end
    finish_test();
  end
endmodule // pll_band_and_lock_regs_test
